/* File: nvsr_pkg.sv */
// What this block does
// - write strobe stays high for reads and goes low for writes
// - six reads in a row, first five at 000, 555, 2aa, 7ff, 0f0
// - write strobe held high in all six steps, else no operation
// - every step is a read timed by chip select falling then rising
// - any other access inside the six reads aborts the sequence
package nvsr_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int NS_PER_US = 1000;
  localparam int NS_PER_MS = 1000000;
  // device busy times, in their own units
  localparam int NV_SAVE_TIME_MS = 10;
  localparam int NV_LOAD_TIME_US = 20;
  localparam int POWERUP_RECALL_TIME_US = 550;
  // the host must wait at least these, so round up
  localparam int NV_SAVE_CYCLES = (NV_SAVE_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NV_LOAD_CYCLES = (NV_LOAD_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERUP_RECALL_CYCLES = (POWERUP_RECALL_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 20;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  // chip select low time: covers access plus the two-stage input sync
  localparam int CS_LOW_CYCLES = 5;
  localparam logic [2:0] CS_LOW_LAST = 3'h4;
  localparam logic [2:0] SEQ_LAST_STEP = 3'h5;
  localparam logic [ADDR_W-1:0] SEQ_ADDR_0 = 11'h000;
  localparam logic [ADDR_W-1:0] SEQ_ADDR_1 = 11'h555;
  localparam logic [ADDR_W-1:0] SEQ_ADDR_2 = 11'h2aa;
  localparam logic [ADDR_W-1:0] SEQ_ADDR_3 = 11'h7ff;
  localparam logic [ADDR_W-1:0] SEQ_ADDR_4 = 11'h0f0;
  localparam logic [ADDR_W-1:0] SEQ_ADDR_SAVE = 11'h70f;
  localparam logic [ADDR_W-1:0] SEQ_ADDR_LOAD = 11'h70e;

  typedef enum logic [1:0] {NVSR_OP_READ, NVSR_OP_WRITE, NVSR_OP_SAVE, NVSR_OP_LOAD} nvsr_op_type;

  typedef struct packed {
    nvsr_op_type op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } nvsr_cmd_type;

  typedef struct packed {
    logic cs_n;
    logic ld_n;
    logic gate_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] io_bus_out;
    logic io_bus_oe;
  } nvsr_pins_type;

  // address of each step of the six-read sequence
  function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] step, input logic is_save);
    logic [ADDR_W-1:0] a;
    a = SEQ_ADDR_0;
    case (step)
      3'h0: a = SEQ_ADDR_0;
      3'h1: a = SEQ_ADDR_1;
      3'h2: a = SEQ_ADDR_2;
      3'h3: a = SEQ_ADDR_3;
      3'h4: a = SEQ_ADDR_4;
      default: a = is_save ? SEQ_ADDR_SAVE : SEQ_ADDR_LOAD;
    endcase
    return a;
  endfunction : seq_addr
endpackage : nvsr_pkg

/* File: nvsr_bus_cycle.sv */
`timescale 1ns/1ps
// one chip-select-timed bus cycle: setup, strobe low, release
module nvsr_bus_cycle (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire logic write_in,
  input wire logic gate_in,
  input wire logic [nvsr_pkg::ADDR_W-1:0] addr_in,
  input wire logic [nvsr_pkg::DATA_W-1:0] wdata_in,
  input wire logic [nvsr_pkg::DATA_W-1:0] io_bus_in,
  output nvsr_pkg::nvsr_pins_type pins_out,
  output logic [nvsr_pkg::DATA_W-1:0] rdata_out,
  output logic done_out
);
  import nvsr_pkg::*;

  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} nvsr_cyc_state_type;

  nvsr_cyc_state_type state;
  nvsr_cyc_state_type next_state;
  logic [2:0] low_cnt;
  logic [DATA_W-1:0] io_meta;
  logic [DATA_W-1:0] io_sync;
  wire strobe_end = (low_cnt == CS_LOW_LAST);

  // state decode
  always_comb begin
    case (state)
      C_IDLE: next_state = start_in ? C_SETUP : C_IDLE;
      C_SETUP: next_state = C_STROBE;
      C_STROBE: next_state = strobe_end ? C_HOLD : C_STROBE;
      C_HOLD: next_state = C_IDLE;
      default: next_state = C_IDLE;
    endcase
  end

  // read data crosses in from the pins through two stages
  always_ff @(posedge clk_in) begin
    io_meta <= io_bus_in;
    io_sync <= io_meta;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state <= C_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // pin drive; write strobe set a full cycle before chip select falls
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pins_out <= '{cs_n: 1'b1, ld_n: 1'b1, gate_n: 1'b1, addr: '0, io_bus_out: '0, io_bus_oe: 1'b0};
      low_cnt <= 3'h0;
      rdata_out <= '0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state)
        C_IDLE: begin
          if (start_in) begin
            pins_out.addr <= addr_in;
            pins_out.ld_n <= ~write_in;
            pins_out.gate_n <= ~(gate_in & ~write_in);
            pins_out.io_bus_out <= wdata_in;
            pins_out.io_bus_oe <= write_in;
          end
        end
        C_SETUP: begin
          pins_out.cs_n <= 1'b0;
          low_cnt <= 3'h0;
        end
        C_STROBE: begin
          low_cnt <= low_cnt + 3'h1;
          if (strobe_end) begin
            pins_out.cs_n <= 1'b1;
            rdata_out <= io_sync;
          end
        end
        C_HOLD: begin
          // address and data held one cycle past the select rise
          pins_out.ld_n <= 1'b1;
          pins_out.gate_n <= 1'b1;
          pins_out.io_bus_oe <= 1'b0;
          done_out <= 1'b1;
        end
        default: begin
          pins_out.cs_n <= 1'b1;
        end
      endcase
    end
  end
endmodule : nvsr_bus_cycle

/* File: nvsr_host.sv */
`timescale 1ns/1ps
// host-side controller for the shadowed static ram
module nvsr_host #(
  parameter int BOOT_WAIT_CYCLES = nvsr_pkg::POWERUP_RECALL_CYCLES,
  parameter int SAVE_WAIT_CYCLES = nvsr_pkg::NV_SAVE_CYCLES
) (
  input wire logic CLK_SYS_IN,
  input wire logic RST_B_IN,
  input wire logic CMD_VALID_IN,
  input wire nvsr_pkg::nvsr_cmd_type CMD_IN,
  input wire logic [nvsr_pkg::DATA_W-1:0] IO_BUS_IN,
  output logic CMD_READY_OUT,
  output logic RSP_VALID_OUT,
  output logic [nvsr_pkg::DATA_W-1:0] RSP_DATA_OUT,
  output logic BUSY_OUT,
  output nvsr_pkg::nvsr_pins_type PINS_OUT
);
  import nvsr_pkg::*;

  typedef enum logic [2:0] {S_BOOT, S_IDLE, S_ACC, S_SEQ, S_WAIT} nvsr_state_type;

  nvsr_state_type state;
  nvsr_state_type next_state;
  logic [CNT_W-1:0] wait_cnt;
  logic [2:0] seq_step;
  logic cur_save;
  logic cur_write;
  logic cur_gate;
  logic [ADDR_W-1:0] cur_addr;
  logic [DATA_W-1:0] cur_wdata;
  logic cyc_start;
  logic cyc_done;
  logic [DATA_W-1:0] cyc_rdata;

  // command and sequence decode
  wire accept = (state == S_IDLE) && CMD_VALID_IN && CMD_READY_OUT;
  wire cmd_nv = (CMD_IN.op == NVSR_OP_SAVE) || (CMD_IN.op == NVSR_OP_LOAD);
  wire seq_last = (seq_step == SEQ_LAST_STEP);
  wire seq_next = (state == S_SEQ) && cyc_done && !seq_last;
  wire wait_end = (wait_cnt == {{(CNT_W-1){1'b0}}, 1'b1});
  wire next_launch = accept || seq_next;
  wire [2:0] launch_step = accept ? 3'h0 : seq_step + 3'h1;
  wire launch_save = accept ? (CMD_IN.op == NVSR_OP_SAVE) : cur_save;
  wire [CNT_W-1:0] nv_wait = cur_save ? CNT_W'(SAVE_WAIT_CYCLES) : CNT_W'(NV_LOAD_CYCLES);

  // top-level control flow
  always_comb begin
    case (state)
      S_BOOT: next_state = wait_end ? S_IDLE : S_BOOT;
      S_IDLE: next_state = accept ? (cmd_nv ? S_SEQ : S_ACC) : S_IDLE;
      S_ACC: next_state = cyc_done ? S_IDLE : S_ACC;
      S_SEQ: next_state = (cyc_done && seq_last) ? S_WAIT : S_SEQ;
      S_WAIT: next_state = wait_end ? S_IDLE : S_WAIT;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      state <= S_BOOT;
    end else begin
      state <= next_state;
    end
  end

  // wait timer: device may still be loading after power-up, or busy after a trigger
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      wait_cnt <= CNT_W'(BOOT_WAIT_CYCLES);
    end else if (state == S_SEQ && cyc_done && seq_last) begin
      wait_cnt <= nv_wait;
    end else if ((state == S_BOOT || state == S_WAIT) && !wait_end) begin
      wait_cnt <= wait_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // cycle request: one access, or the next step of the six reads
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      cyc_start <= 1'b0;
      seq_step <= 3'h0;
      cur_save <= 1'b0;
      cur_write <= 1'b0;
      cur_gate <= 1'b0;
      cur_addr <= '0;
      cur_wdata <= '0;
    end else begin
      cyc_start <= next_launch;
      if (accept && !cmd_nv) begin
        cur_write <= (CMD_IN.op == NVSR_OP_WRITE);
        cur_gate <= 1'b1;
        cur_addr <= CMD_IN.addr;
        cur_wdata <= CMD_IN.wdata;
      end else if (next_launch) begin
        seq_step <= launch_step;
        cur_save <= launch_save;
        cur_write <= 1'b0;
        // the trigger read returns nothing, so the gate stays shut
        cur_gate <= (launch_step != SEQ_LAST_STEP);
        cur_addr <= seq_addr(launch_step, launch_save);
      end
    end
  end

  // user answer; the command port stays closed through the sequence
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      CMD_READY_OUT <= 1'b0;
      BUSY_OUT <= 1'b1;
      RSP_VALID_OUT <= 1'b0;
      RSP_DATA_OUT <= '0;
    end else begin
      CMD_READY_OUT <= (next_state == S_IDLE) && !accept;
      BUSY_OUT <= (next_state != S_IDLE);
      RSP_VALID_OUT <= (state == S_ACC && cyc_done) || (state == S_WAIT && wait_end);
      if (state == S_ACC && cyc_done) begin
        RSP_DATA_OUT <= cur_write ? cur_wdata : cyc_rdata;
      end
    end
  end

  nvsr_bus_cycle u_cycle (
    .clk_in(CLK_SYS_IN),
    .rst_b_in(RST_B_IN),
    .start_in(cyc_start),
    .write_in(cur_write),
    .gate_in(cur_gate),
    .addr_in(cur_addr),
    .wdata_in(cur_wdata),
    .io_bus_in(IO_BUS_IN),
    .pins_out(PINS_OUT),
    .rdata_out(cyc_rdata),
    .done_out(cyc_done)
  );

  // checks on the pins the host drives
  a_read_strobe_high: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (state == S_ACC && !cur_write && !PINS_OUT.cs_n) |-> PINS_OUT.ld_n)
    else $error("write strobe low during a read");
  a_write_strobe_low: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    ($fell(PINS_OUT.cs_n) && state == S_ACC && cur_write) |-> !$past(PINS_OUT.ld_n) && PINS_OUT.io_bus_oe)
    else $error("write strobe not set before select fell");
  a_seq_addr_order: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    ($fell(PINS_OUT.cs_n) && state == S_SEQ) |-> PINS_OUT.addr == seq_addr(seq_step, cur_save))
    else $error("sequence step at wrong address");
  a_seq_strobe_high: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (state == S_SEQ) |-> PINS_OUT.ld_n && !PINS_OUT.io_bus_oe)
    else $error("write strobe or data drive inside sequence");
  a_seq_cs_pulse: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    ($fell(PINS_OUT.cs_n) && state == S_SEQ) |-> !PINS_OUT.cs_n [*5] ##1 PINS_OUT.cs_n)
    else $error("sequence select pulse has wrong length");
  a_seq_no_intrude: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (state == S_SEQ) |-> !CMD_READY_OUT ##1 (state == S_SEQ || state == S_WAIT))
    else $error("access can intrude on sequence");
  a_trigger_gate_shut: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (state == S_SEQ && seq_last && !PINS_OUT.cs_n) |-> PINS_OUT.gate_n)
    else $error("output gate open on trigger read");
  // helper count of cycles spent waiting, kept apart from the wait timer it checks
  logic [CNT_W-1:0] wait_len;
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN || state != S_WAIT) begin
      wait_len <= '0;
    end else begin
      wait_len <= wait_len + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end
  a_nv_wait_length: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (state == S_WAIT && wait_end && !cur_save) |-> wait_len == CNT_W'(NV_LOAD_CYCLES - 1) ##1 RSP_VALID_OUT)
    else $error("load wait has wrong length");
  a_boot_closed: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (state == S_BOOT) |-> BUSY_OUT && !CMD_READY_OUT && PINS_OUT.cs_n)
    else $error("bus used during power-up load");
  c_save_done: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (state == S_WAIT && cur_save && wait_end));
  c_load_done: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (state == S_WAIT && !cur_save && wait_end));
  c_read_done: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (state == S_ACC && cyc_done && !cur_write));
  c_write_done: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (state == S_ACC && cyc_done && cur_write));
endmodule : nvsr_host

/* File: nvsr_dev_model.sv */
`timescale 1ns/1ps
// pin model of the shadowed ram; busy times are counted on the system clock
module nvsr_dev_model #(
  parameter int SAVE_BUSY = 48,
  parameter int LOAD_BUSY = 790,
  parameter int BOOT_BUSY = 18
) (
  input wire logic clk_in,
  input wire nvsr_pkg::nvsr_pins_type pins_in,
  input wire logic [7:0] io_bus_in,
  output logic [7:0] io_bus_out,
  output logic io_bus_oe,
  output int n_save,
  output int n_load,
  output int n_viol
);
  import nvsr_pkg::*;
  logic [7:0] ram [2048];
  logic [7:0] shadow [2048];
  logic [ADDR_W-1:0] seq [5];
  int busy;
  int step;
  logic wr_fall;
  logic trig;
  // power-up load: array filled from the shadow before any access
  initial begin
    seq = '{SEQ_ADDR_0, SEQ_ADDR_1, SEQ_ADDR_2, SEQ_ADDR_3, SEQ_ADDR_4};
    foreach (shadow[i]) shadow[i] = 8'(i) ^ 8'h5a;
    ram = shadow;
    busy = BOOT_BUSY;
    step = 0;
    n_save = 0;
    n_load = 0;
    n_viol = 0;
    wr_fall = 1'b0;
    trig = 1'b0;
  end
  // busy swallows every bus cycle until it runs out
  always @(posedge clk_in) if (busy > 0) busy = busy - 1;
  // select fall: note a write strobe already low and a triggering sixth step
  always @(negedge pins_in.cs_n) begin
    if (busy > 0) n_viol++;
    wr_fall = !pins_in.ld_n;
    trig = step == 5 && (pins_in.addr == SEQ_ADDR_SAVE || pins_in.addr == SEQ_ADDR_LOAD);
  end
  // outputs only on a plain read: gate low, strobe high from select fall
  assign io_bus_oe = busy == 0 && !pins_in.cs_n && !pins_in.gate_n && pins_in.ld_n && !wr_fall && !trig;
  assign io_bus_out = ram[pins_in.addr];
  // each step is taken on the select rise; any write breaks the run
  always @(posedge pins_in.cs_n) begin
    if (busy == 0) begin
      if (!pins_in.ld_n || wr_fall) begin
        if (!pins_in.ld_n) ram[pins_in.addr] = io_bus_in;
        step = 0;
      end else if (step < 5) begin
        // a miss that lands on the first address opens a new run
        step = pins_in.addr == seq[step] ? step + 1 : (pins_in.addr == SEQ_ADDR_0 ? 1 : 0);
      end else begin
        step = 0;
        if (pins_in.addr == SEQ_ADDR_SAVE) begin
          shadow = ram;
          n_save++;
          busy = SAVE_BUSY;
        end else if (pins_in.addr == SEQ_ADDR_LOAD) begin
          foreach (ram[i]) ram[i] = 8'h00;
          ram = shadow;
          n_load++;
          busy = LOAD_BUSY;
        end else if (pins_in.addr == SEQ_ADDR_0) begin
          step = 1;
        end
      end
    end
  end
endmodule : nvsr_dev_model

/* File: nv_sram_store_recall_seq_tb_top.sv */
`timescale 1ns/1ps
// host controller against the pin model of the shadowed ram
module nv_sram_store_recall_seq_tb_top;
  import nvsr_pkg::*;
  typedef struct {nvsr_op_type op; logic [10:0] a; logic [7:0] d; logic [7:0] e;} nvsr_row_type;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  nvsr_cmd_type cmd = '0;
  logic [7:0] io_wire;
  logic [7:0] io_last = 8'h00;
  logic cmd_ready, rsp_valid, busy, dev_oe;
  logic [7:0] rsp_data, dev_out;
  nvsr_pins_type pins;
  int n_save, n_load, n_viol;
  int mismatches = 0;
  int n_checks = 0;
  int n_clash = 0;
  // plain accesses; first and last read show the power-up contents
  nvsr_row_type rows [6] = '{
    '{NVSR_OP_READ, 11'h123, 8'h00, 8'h79}, '{NVSR_OP_WRITE, 11'h555, 8'ha5, 8'ha5},
    '{NVSR_OP_READ, 11'h555, 8'h00, 8'ha5}, '{NVSR_OP_WRITE, 11'h7ff, 8'h3c, 8'h3c},
    '{NVSR_OP_READ, 11'h7ff, 8'h00, 8'h3c}, '{NVSR_OP_READ, 11'h000, 8'h00, 8'h5a}};
  always #12.5 clk = ~clk;
  nvsr_host #(.BOOT_WAIT_CYCLES(20), .SAVE_WAIT_CYCLES(50)) DUT (.CLK_SYS_IN(clk), .RST_B_IN(rst_b),
    .CMD_VALID_IN(cmd_valid), .CMD_IN(cmd), .IO_BUS_IN(io_wire), .CMD_READY_OUT(cmd_ready),
    .RSP_VALID_OUT(rsp_valid), .RSP_DATA_OUT(rsp_data), .BUSY_OUT(busy), .PINS_OUT(pins));
  nvsr_dev_model model (.clk_in(clk), .pins_in(pins), .io_bus_in(io_wire), .io_bus_out(dev_out),
    .io_bus_oe(dev_oe), .n_save(n_save), .n_load(n_load), .n_viol(n_viol));
  // a released bus shows the inverse of its last driven value, so stale data never passes
  assign io_wire = pins.io_bus_oe ? pins.io_bus_out : dev_oe ? dev_out : ~io_last;
  always @(posedge clk) begin
    if (pins.io_bus_oe || dev_oe) io_last <= io_wire;
    if (pins.io_bus_oe && dev_oe) n_clash++;
  end
  task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", what, e, g);
    end
  endtask : chk_val
  // one command: held until taken, then wait for the answer pulse
  task automatic do_cmd(input nvsr_op_type op, input logic [10:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    #2;
    cmd = '{op, a, d};
    cmd_valid = 1'b1;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 3000) begin
      @(posedge clk);
      #2;
      k++;
    end
    @(posedge clk);
    #2;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && k < 3000) begin
      @(posedge clk);
      #2;
      k++;
    end
    chk_val("handshake wait", 0, k >= 3000);
    chk_val("busy after answer", 0, busy);
    chk_val("cs_n after answer", 1, pins.cs_n);
  endtask : do_cmd
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  // watchdog: the whole run needs about 2000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk);
    #2;
    chk_val("cs_n in reset", 1, pins.cs_n);
    chk_val("oe in reset", 0, pins.io_bus_oe);
    chk_val("ready in reset", 0, cmd_ready);
    chk_val("busy in reset", 1, busy);
    rst_b = 1'b1;
    foreach (rows[i]) begin
      do_cmd(rows[i].op, rows[i].a, rows[i].d);
      chk_val("row data", rows[i].e, rsp_data);
    end
    chk_val("stray ops", 0, n_save + n_load);
    // save, overwrite at once, then load twice: shadow must survive both
    do_cmd(NVSR_OP_SAVE, 11'h000, 8'h00);
    chk_val("save count", 1, n_save);
    do_cmd(NVSR_OP_WRITE, 11'h555, 8'h11);
    do_cmd(NVSR_OP_READ, 11'h555, 8'h00);
    chk_val("overwrite", 8'h11, rsp_data);
    do_cmd(NVSR_OP_LOAD, 11'h000, 8'h00);
    chk_val("load count", 1, n_load);
    do_cmd(NVSR_OP_READ, 11'h555, 8'h00);
    chk_val("loaded data", 8'ha5, rsp_data);
    do_cmd(NVSR_OP_WRITE, 11'h7ff, 8'h00);
    do_cmd(NVSR_OP_LOAD, 11'h000, 8'h00);
    do_cmd(NVSR_OP_READ, 11'h7ff, 8'h00);
    chk_val("second load", 8'h3c, rsp_data);
    chk_val("bus clash", 0, n_clash);
    chk_val("access while busy", 0, n_viol);
    chk_val("second load count", 2, n_load);
    // reset in mid-run: pins close and the boot wait starts over
    @(posedge clk);
    #2;
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    chk_val("cs_n in second reset", 1, pins.cs_n);
    chk_val("ready in second reset", 0, cmd_ready);
    chk_val("busy in second reset", 1, busy);
    rst_b = 1'b1;
    do_cmd(NVSR_OP_READ, 11'h555, 8'h00);
    chk_val("read after reset", 8'ha5, rsp_data);
    test_done();
  end
endmodule : nv_sram_store_recall_seq_tb_top
